// File: torque_cfg.svh
// Constants for the torque command conditioning block
`ifndef TORQUE_CFG_SVH
`define TORQUE_CFG_SVH

// Clock and sample tick (one tick per filter time unit)
`define TQ_CLK_PERIOD_NS   5
`define TQ_TICK_NS         10000
`define TQ_TICK_CYCLES     (`TQ_TICK_NS / `TQ_CLK_PERIOD_NS)
`define TQ_TICKS_PER_MS    (1000000 / `TQ_TICK_NS)
// Automatic zero-set duration
`define TQ_ZERO_TIME_MS    3000
`define TQ_ZERO_TICKS      (`TQ_ZERO_TIME_MS * `TQ_TICKS_PER_MS)
`define TQ_DRIFT_LIMIT_MV  500

// Control mode codes
`define TQ_MODE_INT        4'h2
`define TQ_MODE_ANA        4'h4

// Register byte offsets
`define TQ_A_CTRL          8'h00
`define TQ_A_INT_TORQUE    8'h04
`define TQ_A_FULL_SCALE    8'h08
`define TQ_A_OFFSET2       8'h0c
`define TQ_A_FILTER        8'h10
`define TQ_A_LO_T          8'h14
`define TQ_A_LO_V          8'h18
`define TQ_A_UP_T          8'h1c
`define TQ_A_UP_V          8'h20
`define TQ_A_RAMP_UP       8'h24
`define TQ_A_RAMP_DN       8'h28
`define TQ_A_STATUS        8'h2c
`define TQ_A_MASK          8'h30
`define TQ_A_TORQUE        8'h34

// Control register fields
`define TQ_CTRL_MODE_HI    3
`define TQ_CTRL_SRC        4
`define TQ_CTRL_ZERO       8
// Status bits
`define TQ_ST_ZERO_DONE    0
`define TQ_ST_ALARM        1

// Reset values
`define TQ_RST_INT_TORQUE  16'h000a
`define TQ_RST_FULL_SCALE  16'h0064
`define TQ_RST_FILTER      16'h00c8
`define TQ_RST_LO          16'hfc18
`define TQ_RST_UP          16'h03e8
`define TQ_RST_SRC         1'b1

// Ranges and scaling
`define TQ_VMAX_MV         10000
`define TQ_OFS_MAX_MV      5000
`define TQ_FS_MIN          1
`define TQ_FS_MAX          800
`define TQ_INT_MAX         800
`define TQ_FILT_MIN        1
`define TQ_FILT_MAX        30000
`define TQ_CAL_MAX         1000
`define TQ_MV_PER_CV       10
`define TQ_PCT_TO_DPCT     10
`define TQ_CAL_DIV         100
`define TQ_FINE            100
`define TQ_RAMP_NUM        10000

`endif

// File: torque_pkg.sv
// Types shared by the torque command conditioning block
package torque_pkg;

	// Zero-set sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_ZERO = 2'b10
	} zero_state_t;

	// Whole state of the block
	typedef struct packed {
		logic        [3:0]  mode;
		logic               src;
		logic        [15:0] int_t;
		logic        [15:0] fs;
		logic        [15:0] ofs;
		logic        [15:0] filt;
		logic        [15:0] lo_t;
		logic        [15:0] lo_v;
		logic        [15:0] up_t;
		logic        [15:0] up_v;
		logic        [15:0] rup;
		logic        [15:0] rdn;
		zero_state_t        zst;
		logic        [15:0] tick_cnt;
		logic        [19:0] zero_cnt;
		logic signed [31:0] acc;
		logic signed [31:0] ramp;
		logic        [15:0] tq;
		logic        [1:0]  sts;
		logic        [1:0]  msk;
		logic        [31:0] rdata;
	} tq_state_t;

endpackage : torque_pkg

// File: torque_command_conditioning.sv
// Torque command conditioning: mode select, analog scaling, filter, zero-set, soft start
`timescale 1ns/100ps
`default_nettype none
`include "torque_cfg.svh"

module torque_command_conditioning #(
	parameter int unsigned ZERO_SET_TICKS = `TQ_ZERO_TICKS // Zero-set length in 10 us ticks
) (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        srst_in,
	// Register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	// Converted analog inputs, signed millivolts
	input  wire logic [15:0] analog_input_one_in,
	input  wire logic [15:0] analog_input_two_in,
	// Torque demand and status
	output logic      [15:0] torque_demand_out,
	output logic             torque_mode_active_out,
	output logic             zero_drift_alarm_out,
	output logic             irq_out
);

	// Sign extension of a 16-bit field
	function automatic logic signed [31:0] sx(input logic [15:0] v);
		sx = {{16{v[15]}}, v};
	endfunction : sx

	// Saturation into a signed window
	function automatic logic signed [31:0] sat(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		if (v < lo) begin
			sat = lo;
		end else if (v > hi) begin
			sat = hi;
		end else begin
			sat = v;
		end
	endfunction : sat

	// Magnitude of a signed value
	function automatic logic signed [31:0] mag(input logic signed [31:0] v);
		mag = (v < 0) ? -v : v;
	endfunction : mag

	localparam logic signed [31:0] VMAX = `TQ_VMAX_MV;      // Input clamp
	localparam logic [15:0] TICK_LAST = 16'(`TQ_TICK_CYCLES - 1); // Divider wrap
	localparam logic [19:0] ZERO_LAST = 20'(ZERO_SET_TICKS - 1);  // Zero-set wrap

	// Reset image of the state
	localparam torque_pkg::tq_state_t RST = '{
		mode: 4'h0, src: `TQ_RST_SRC, int_t: `TQ_RST_INT_TORQUE,
		fs: `TQ_RST_FULL_SCALE, ofs: 16'h0000, filt: `TQ_RST_FILTER,
		lo_t: `TQ_RST_LO, lo_v: `TQ_RST_LO, up_t: `TQ_RST_UP, up_v: `TQ_RST_UP,
		rup: 16'h0000, rdn: 16'h0000, zst: torque_pkg::ST_RUN,
		tick_cnt: 16'h0000, zero_cnt: 20'h00000, acc: 32'sh0, ramp: 32'sh0,
		tq: 16'h0000, sts: 2'h0, msk: 2'h0, rdata: 32'h0000_0000};

	torque_pkg::tq_state_t q;      // Registered state
	torque_pkg::tq_state_t s;      // Next state

	logic               tick;      // 10 us enable
	logic               active;    // A torque mode is selected
	logic signed [31:0] raw1;      // First input, clamped
	logic signed [31:0] raw2;      // Second input, offset corrected and clamped
	logic signed [31:0] x;         // Selected command
	logic signed [31:0] y;         // Filtered command, mV
	logic signed [31:0] vl;        // Lower point, mV
	logic signed [31:0] vu;        // Upper point, mV
	logic signed [31:0] tl;        // Lower point torque, 0.1 %
	logic signed [31:0] tu;        // Upper point torque, 0.1 %
	logic signed [31:0] vc;        // Voltage clamped to the calibrated span
	logic signed [31:0] ana;       // Analog torque, 0.1 %
	logic signed [31:0] target;    // Torque target, 0.1 %
	logic signed [31:0] tgt_f;     // Target in fine ramp units
	logic signed [31:0] step;      // Ramp increment per tick
	logic signed [31:0] drift;     // Zero-set measurement
	logic        [15:0] rtime;     // Ramp time in use
	logic               away;      // Magnitude is growing

	// Data path and control, from registered state and the live analog and register port inputs
	always_comb begin
		s = q;
		s.rdata = 32'h0000_0000;
		tick = (q.tick_cnt == TICK_LAST);
		s.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;
		active = (q.mode == `TQ_MODE_INT) || (q.mode == `TQ_MODE_ANA);

		// Inputs held within the accepted voltage span
		raw1 = sat(sx(analog_input_one_in), -VMAX, VMAX);
		raw2 = sat(sx(analog_input_two_in) + sx(q.ofs), -VMAX, VMAX);
		x = q.src ? raw2 : raw1;

		// First-order filter kept as y*T so small errors still converge
		y = q.acc / sx(q.filt);
		if (tick) begin
			s.acc = q.acc + x - y;
		end

		// Calibration points: voltages scaled to mV, torques scaled by the full-scale torque
		vl = sx(q.lo_v) * `TQ_MV_PER_CV;
		vu = sx(q.up_v) * `TQ_MV_PER_CV;
		tl = sx(q.fs) * sx(q.lo_t) / `TQ_CAL_DIV;
		tu = sx(q.fs) * sx(q.up_t) / `TQ_CAL_DIV;
		vc = sat(y, vl, vu);
		// Degenerate span falls back to the lower point torque
		if (vu <= vl) begin
			ana = tl;
		end else begin
			ana = tl + (vc - vl) * (tu - tl) / (vu - vl);
		end

		// Torque target by mode
		case (q.mode)
			`TQ_MODE_INT: target = sx(q.int_t) * `TQ_PCT_TO_DPCT;
			`TQ_MODE_ANA: target = ana;
			default:      target = 32'sh0;
		endcase

		// Soft start: fixed slope, full rated swing in the set time
		tgt_f = target * `TQ_FINE;
		away = (tgt_f >= 0) ? ((tgt_f > q.ramp) && (q.ramp >= 0))
			: ((tgt_f < q.ramp) && (q.ramp <= 0));
		rtime = away ? q.rup : q.rdn;
		step = (rtime == 16'h0000) ? 32'sh0
			: sat(`TQ_RAMP_NUM / {16'h0000, rtime}, 32'sh1, VMAX);
		if (!active) begin
			// Leaving torque mode drops the demand at once
			s.ramp = 32'sh0;
		end else if (tick) begin
			if ((rtime == 16'h0000) || (mag(tgt_f - q.ramp) <= step)) begin
				s.ramp = tgt_f;
			end else if (tgt_f > q.ramp) begin
				s.ramp = q.ramp + step;
			end else begin
				s.ramp = q.ramp - step;
			end
		end
		s.tq = 16'(s.ramp / `TQ_FINE);

		// Zero-set: wait, then sample the second input taken as 0 V
		drift = sx(analog_input_two_in);
		case (q.zst)
			torque_pkg::ST_RUN: begin
				s.zero_cnt = 20'h00000;
			end
			torque_pkg::ST_ZERO: begin
				if (tick) begin
					s.zero_cnt = q.zero_cnt + 20'h00001;
					if (q.zero_cnt == ZERO_LAST) begin
						s.zst = torque_pkg::ST_RUN;
						if (mag(drift) > `TQ_DRIFT_LIMIT_MV) begin
							// Offset left untouched when the drift is implausible
							s.sts[`TQ_ST_ALARM] = 1'b1;
						end else begin
							s.ofs = 16'(-drift);
							s.sts[`TQ_ST_ZERO_DONE] = 1'b1;
						end
					end
				end
			end
			default: begin
				s.zst = torque_pkg::ST_RUN;
			end
		endcase

		// Register writes take effect on the next cycle
		if (reg_wr_in) begin
			case (reg_addr_in)
				`TQ_A_CTRL: begin
					s.mode = reg_wdata_in[`TQ_CTRL_MODE_HI:0];
					s.src = reg_wdata_in[`TQ_CTRL_SRC];
					if (reg_wdata_in[`TQ_CTRL_ZERO] && (q.zst == torque_pkg::ST_RUN)) begin
						s.zst = torque_pkg::ST_ZERO;
					end
				end
				`TQ_A_INT_TORQUE: s.int_t = 16'(sat(sx(reg_wdata_in[15:0]),
					-`TQ_INT_MAX, `TQ_INT_MAX));
				`TQ_A_FULL_SCALE: s.fs = 16'(sat(sx(reg_wdata_in[15:0]),
					`TQ_FS_MIN, `TQ_FS_MAX));
				`TQ_A_OFFSET2: s.ofs = 16'(sat(sx(reg_wdata_in[15:0]),
					-`TQ_OFS_MAX_MV, `TQ_OFS_MAX_MV));
				`TQ_A_FILTER: s.filt = 16'(sat(sx(reg_wdata_in[15:0]),
					`TQ_FILT_MIN, `TQ_FILT_MAX));
				`TQ_A_LO_T: s.lo_t = 16'(sat(sx(reg_wdata_in[15:0]),
					-`TQ_CAL_MAX, `TQ_CAL_MAX));
				`TQ_A_LO_V: s.lo_v = 16'(sat(sx(reg_wdata_in[15:0]),
					-`TQ_CAL_MAX, `TQ_CAL_MAX));
				`TQ_A_UP_T: s.up_t = 16'(sat(sx(reg_wdata_in[15:0]),
					-`TQ_CAL_MAX, `TQ_CAL_MAX));
				`TQ_A_UP_V: s.up_v = 16'(sat(sx(reg_wdata_in[15:0]),
					-`TQ_CAL_MAX, `TQ_CAL_MAX));
				`TQ_A_RAMP_UP: s.rup = reg_wdata_in[15:0];
				`TQ_A_RAMP_DN: s.rdn = reg_wdata_in[15:0];
				// Write one to clear; an event in the same cycle wins unless its bit was already pending
				`TQ_A_STATUS: s.sts = (q.sts & ~reg_wdata_in[1:0]) | (s.sts & ~q.sts);
				`TQ_A_MASK: s.msk = reg_wdata_in[1:0];
				default: begin
				end
			endcase
		end

		// Reads answer one cycle later; unmapped reads return zero
		if (reg_rd_in) begin
			case (reg_addr_in)
				`TQ_A_CTRL: s.rdata = {23'h0, q.zst == torque_pkg::ST_ZERO, 3'h0,
					q.src, q.mode};
				`TQ_A_INT_TORQUE: s.rdata = sx(q.int_t);
				`TQ_A_FULL_SCALE: s.rdata = {16'h0000, q.fs};
				`TQ_A_OFFSET2:    s.rdata = sx(q.ofs);
				`TQ_A_FILTER:     s.rdata = {16'h0000, q.filt};
				`TQ_A_LO_T:       s.rdata = sx(q.lo_t);
				`TQ_A_LO_V:       s.rdata = sx(q.lo_v);
				`TQ_A_UP_T:       s.rdata = sx(q.up_t);
				`TQ_A_UP_V:       s.rdata = sx(q.up_v);
				`TQ_A_RAMP_UP:    s.rdata = {16'h0000, q.rup};
				`TQ_A_RAMP_DN:    s.rdata = {16'h0000, q.rdn};
				`TQ_A_STATUS:     s.rdata = {30'h0, q.sts};
				`TQ_A_MASK:       s.rdata = {30'h0, q.msk};
				`TQ_A_TORQUE:     s.rdata = sx(q.tq);
				default:          s.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register, synchronous reset
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			q <= RST;
		end else begin
			q <= s;
		end
	end

	// Outputs from flip-flops, mode flag decoded from the mode field, interrupt gated by the mask
	assign reg_rdata_out          = q.rdata;
	assign torque_demand_out      = q.tq;
	assign torque_mode_active_out = (q.mode == `TQ_MODE_INT) || (q.mode == `TQ_MODE_ANA);
	assign zero_drift_alarm_out   = q.sts[`TQ_ST_ALARM];
	assign irq_out                = |(q.sts & q.msk);

	// Cycles spent in zero-set, for the duration check
	logic [31:0] zero_cycles;
	always_ff @(posedge core_clk_in) begin
		if (srst_in || (q.zst != torque_pkg::ST_ZERO)) begin
			zero_cycles <= 32'h0;
		end else begin
			zero_cycles <= zero_cycles + 32'h1;
		end
	end
	localparam logic [31:0] ZERO_MAX = 32'((ZERO_SET_TICKS + 1) * `TQ_TICK_CYCLES);

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (srst_in);

	chk_mode_off_zero: assert property (!active |=> torque_demand_out == 16'h0000)
		else $error("demand not zero outside torque mode");
	// With no ramp time the stored torque must reach the pin one cycle after a tick
	chk_int_target: assert property ((q.mode == `TQ_MODE_INT) && tick && (q.rup == 16'h0000)
		&& (q.rdn == 16'h0000) && !reg_wr_in
		|=> $signed(torque_demand_out) == $signed(q.int_t) * `TQ_PCT_TO_DPCT)
		else $error("internal torque not applied at once");
	// Judged against the pins themselves, not the internal clamp path
	chk_source_pick: assert property ((q.ofs == 16'h0000)
		&& (mag(sx(analog_input_one_in)) <= VMAX) && (mag(sx(analog_input_two_in)) <= VMAX)
		|-> x == (q.src ? $signed(analog_input_two_in) : $signed(analog_input_one_in)))
		else $error("analog source not as selected");
	chk_zero_length: assert property (zero_cycles <= ZERO_MAX)
		else $error("zero-set overran its time");
	chk_drift_alarm: assert property ((q.zst == torque_pkg::ST_ZERO) && tick
		&& (q.zero_cnt == ZERO_LAST) && (mag(drift) > `TQ_DRIFT_LIMIT_MV)
		|=> zero_drift_alarm_out && (q.zst == torque_pkg::ST_RUN))
		else $error("drift alarm missing");
	chk_filter_hold: assert property (!tick |=> $stable(q.acc))
		else $error("filter moved between ticks");
	chk_interp_span: assert property ((q.mode == `TQ_MODE_ANA) && (vu > vl)
		|-> ((ana >= tl) && (ana <= tu)) || ((ana <= tl) && (ana >= tu)))
		else $error("interpolated torque outside calibration span");
	chk_ramp_toward: assert property (active && tick && $stable(q.mode)
		|=> mag($past(tgt_f) - q.ramp) <= mag($past(tgt_f) - $past(q.ramp)))
		else $error("ramp moved away from target");
	chk_ramp_instant: assert property (active && tick && (q.rup == 16'h0000)
		&& (q.rdn == 16'h0000) |=> q.ramp == $past(tgt_f))
		else $error("zero ramp time did not apply at once");
	// An unmasked pending event keeps the line up until status or mask is written
	chk_irq_level: assert property (((q.sts & q.msk) != 2'b00)
		&& !(reg_wr_in && ((reg_addr_in == `TQ_A_STATUS) || (reg_addr_in == `TQ_A_MASK)))
		|=> irq_out)
		else $error("interrupt dropped without a clear");

endmodule : torque_command_conditioning
`default_nettype wire

// File: torque_host_model.sv
// Host controller model driving the two converted analog command inputs
`timescale 1ns/100ps
`default_nettype none

module torque_host_model (
	// Requested command voltages, signed mV
	input  wire logic [15:0] cmd_one_in,
	input  wire logic [15:0] cmd_two_in,
	// Converter drift seen while the input is grounded
	input  wire logic [15:0] drift_in,
	input  wire logic        zero_hold_in,
	// Voltages seen by the drive, signed mV
	output logic      [15:0] analog_input_one_out,
	output logic      [15:0] analog_input_two_out
);
	// Host output stage cannot swing past ten volts either way
	function automatic logic [15:0] clamp_mv(input logic [15:0] v);
		if ($signed(v) > $signed(16'h2710)) return 16'h2710;
		if ($signed(v) < $signed(16'hd8f0)) return 16'hd8f0;
		return v;
	endfunction : clamp_mv

	// Grounded input leaves only the drift, so zero-set sees a real offset
	always_comb begin
		if (zero_hold_in) begin
			analog_input_one_out = drift_in;
			analog_input_two_out = drift_in;
		end else begin
			analog_input_one_out = clamp_mv(cmd_one_in);
			analog_input_two_out = clamp_mv(cmd_two_in);
		end
	end
endmodule : torque_host_model
`default_nettype wire

// File: test_torque_command_conditioning.sv
// Self-checking bench for the torque command conditioning block
`timescale 1ns/100ps
`default_nettype none
`include "torque_cfg.svh"

module test_torque_command_conditioning;
	localparam int ZT   = 4;               // Short zero-set, keeps the run brief
	localparam int TICK = `TQ_TICK_CYCLES; // Sample tick in clocks
	logic        core_clk_in;
	logic        srst_in;
	logic [7:0]  reg_addr_in;
	logic [31:0] reg_wdata_in;
	logic        reg_wr_in;
	logic        reg_rd_in;
	logic [31:0] reg_rdata_out;
	logic [15:0] ain_one;
	logic [15:0] ain_two;
	logic [15:0] cmd_one;
	logic [15:0] cmd_two;
	logic [15:0] drift;
	logic        zero_hold;
	logic [15:0] torque_demand_out;
	logic        torque_mode_active_out;
	logic        zero_drift_alarm_out;
	logic        irq_out;
	int          bad_count;
	int          comparisons;

	// Device under test
	torque_command_conditioning #(.ZERO_SET_TICKS(ZT)) dut_u (
		.core_clk_in(core_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .analog_input_one_in(ain_one),
		.analog_input_two_in(ain_two), .torque_demand_out(torque_demand_out),
		.torque_mode_active_out(torque_mode_active_out),
		.zero_drift_alarm_out(zero_drift_alarm_out), .irq_out(irq_out));

	// Far-side host
	torque_host_model host_u (
		.cmd_one_in(cmd_one), .cmd_two_in(cmd_two), .drift_in(drift),
		.zero_hold_in(zero_hold), .analog_input_one_out(ain_one),
		.analog_input_two_out(ain_two));

	// 200 MHz clock
	initial begin
		core_clk_in = 1'b0;
		forever #2.5 core_clk_in = ~core_clk_in;
	end

	// Verdict and end of run
	task automatic test_done;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done

	// Register word compare
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t register got %h expected %h", $time, got, exp);
		end
	endtask : check_reg

	// Output pin compare
	task automatic check_out(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t output got %h expected %h", $time, got, exp);
		end
	endtask : check_out

	// One-cycle write strobe
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in    <= 1'b0;
	endtask : reg_write

	// One-cycle read strobe, data taken in the following cycle only
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in   <= 1'b0;
		#1 d = reg_rdata_out;
	endtask : reg_read

	// Bounded wait for a torque value, then compare
	task automatic wait_torque(input logic [15:0] exp);
		int n;
		n = 0;
		#1;
		while (torque_demand_out !== exp && n < 3 * TICK) begin
			@(posedge core_clk_in);
			#1 n++;
		end
		check_out(torque_demand_out, exp);
	endtask : wait_torque

	// Bounded wait for any torque change, returns value and clocks taken
	task automatic wait_change(output logic [15:0] v, output int n);
		logic [15:0] s;
		#1;
		s = torque_demand_out;
		n = 0;
		while (torque_demand_out === s && n < 3 * TICK) begin
			@(posedge core_clk_in);
			#1 n++;
		end
		v = torque_demand_out;
	endtask : wait_change

	// Settings after reset, including a hole in the map
	task automatic test_reset_values;
		logic [31:0] d;
		reg_read(`TQ_A_CTRL, d);       check_reg(d, 32'h00000010);
		reg_read(`TQ_A_INT_TORQUE, d); check_reg(d, 32'h0000000a);
		reg_read(`TQ_A_FULL_SCALE, d); check_reg(d, 32'h00000064);
		reg_read(`TQ_A_OFFSET2, d);    check_reg(d, 32'h00000000);
		reg_read(`TQ_A_FILTER, d);     check_reg(d, 32'h000000c8);
		reg_read(`TQ_A_LO_T, d);       check_reg(d, 32'hfffffc18);
		reg_read(`TQ_A_LO_V, d);       check_reg(d, 32'hfffffc18);
		reg_read(`TQ_A_UP_T, d);       check_reg(d, 32'h000003e8);
		reg_read(`TQ_A_UP_V, d);       check_reg(d, 32'h000003e8);
		reg_read(8'h40, d);            check_reg(d, 32'h00000000);
		check_out(torque_demand_out, 16'h0000);
		check_out({15'h0000, torque_mode_active_out}, 16'h0000);
	endtask : test_reset_values

	// Out-of-range settings clip at their limits
	task automatic test_saturation;
		logic [31:0] d;
		reg_write(`TQ_A_INT_TORQUE, 32'h00000384);
		reg_read(`TQ_A_INT_TORQUE, d); check_reg(d, 32'h00000320);
		reg_write(`TQ_A_INT_TORQUE, 32'hfffffc7c);
		reg_read(`TQ_A_INT_TORQUE, d); check_reg(d, 32'hfffffce0);
		reg_write(`TQ_A_FULL_SCALE, 32'h00000000);
		reg_read(`TQ_A_FULL_SCALE, d); check_reg(d, 32'h00000001);
		reg_write(`TQ_A_FULL_SCALE, 32'h00000064);
		reg_write(`TQ_A_FILTER, 32'h00000000);
		reg_read(`TQ_A_FILTER, d);     check_reg(d, 32'h00000001);
	endtask : test_saturation

	// Stored torque applies at once and follows edits live
	task automatic test_internal_mode;
		reg_write(`TQ_A_INT_TORQUE, 32'h00000019);
		reg_write(`TQ_A_CTRL, 32'h00000012);
		#1 check_out({15'h0000, torque_mode_active_out}, 16'h0001);
		wait_torque(16'h00fa);
		reg_write(`TQ_A_INT_TORQUE, 32'hffffffe2);
		wait_torque(16'hfed4);
		reg_write(`TQ_A_CTRL, 32'h00000010);
		repeat (2) @(posedge core_clk_in);
		#1 check_out(torque_demand_out, 16'h0000);
		check_out({15'h0000, torque_mode_active_out}, 16'h0000);
	endtask : test_internal_mode

	// Zero-set: small drift compensated, large drift alarms, masked irq
	task automatic test_zero_set;
		logic [31:0] d;
		@(posedge core_clk_in);
		zero_hold <= 1'b1;
		drift     <= 16'h0078;
		reg_write(`TQ_A_MASK, 32'h00000001);
		reg_write(`TQ_A_CTRL, 32'h00000114);
		reg_read(`TQ_A_CTRL, d); check_reg(d, 32'h00000114);
		for (int i = 0; i < (ZT + 2) * TICK && irq_out !== 1'b1; i++) @(posedge core_clk_in);
		#1 check_out({15'h0000, irq_out}, 16'h0001);
		reg_read(`TQ_A_OFFSET2, d); check_reg(d, 32'hffffff88);
		reg_write(`TQ_A_STATUS, 32'h00000001);
		reg_read(`TQ_A_CTRL, d); check_reg(d, 32'h00000014);
		check_out({15'h0000, irq_out}, 16'h0000);
		drift <= 16'h02bc;
		reg_write(`TQ_A_CTRL, 32'h00000114);
		for (int i = 0; i < (ZT + 2) * TICK && zero_drift_alarm_out !== 1'b1; i++)
			@(posedge core_clk_in);
		#1 check_out({15'h0000, zero_drift_alarm_out}, 16'h0001);
		check_out({15'h0000, irq_out}, 16'h0000);
		reg_read(`TQ_A_STATUS, d); check_reg(d, 32'h00000002);
		reg_read(`TQ_A_OFFSET2, d); check_reg(d, 32'hffffff88);
		reg_write(`TQ_A_STATUS, 32'h00000002);
		zero_hold <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		#1 check_out({15'h0000, zero_drift_alarm_out}, 16'h0000);
	endtask : test_zero_set

	// Source choice, offset on second input, scaling and interpolation
	task automatic test_analog_mode;
		cmd_one <= 16'h1388;
		cmd_two <= 16'h07d0;
		reg_write(`TQ_A_CTRL, 32'h00000004);
		wait_torque(16'h01f4);
		reg_write(`TQ_A_CTRL, 32'h00000014);
		wait_torque(16'h00bc);
		reg_write(`TQ_A_FULL_SCALE, 32'h00000032);
		wait_torque(16'h005e);
	endtask : test_analog_mode

	// Steps become constant-slope ramps, rise and fall rates apart
	task automatic test_soft_start;
		logic [15:0] v;
		int          n;
		logic [31:0] d;
		reg_write(`TQ_A_RAMP_UP, 32'h0000000a);
		reg_write(`TQ_A_FULL_SCALE, 32'h00000064);
		wait_change(v, n); check_out(v, 16'h0068);
		wait_change(v, n); check_out(v, 16'h0072);
		check_reg(n, TICK);
		reg_write(`TQ_A_RAMP_DN, 32'h00000014);
		reg_write(`TQ_A_FULL_SCALE, 32'h00000032);
		wait_change(v, n); check_out(v, 16'h006d);
		reg_read(`TQ_A_TORQUE, d); check_reg(d, 32'h0000006d);
	endtask : test_soft_start

	// Hang guard, under the cycle budget and well above the expected run
	initial begin
		repeat (90000) @(posedge core_clk_in);
		bad_count++;
		test_done();
	end

	// Main sequence
	initial begin
		bad_count    = 0;
		comparisons  = 0;
		srst_in      = 1'b1;
		reg_addr_in  = 8'h00;
		reg_wdata_in = 32'h00000000;
		reg_wr_in    = 1'b0;
		reg_rd_in    = 1'b0;
		cmd_one      = 16'h0000;
		cmd_two      = 16'h0000;
		drift        = 16'h0000;
		zero_hold    = 1'b0;
		repeat (10) @(posedge core_clk_in);
		srst_in <= 1'b0;
		test_reset_values();
		test_saturation();
		test_internal_mode();
		test_zero_set();
		test_analog_mode();
		test_soft_start();
		test_done();
	end
endmodule : test_torque_command_conditioning
`default_nettype wire
